/* rtl/mls_map.vh */
// What this block does
// - Compare accepted label bits 3 to 5 against fixed expected code 100.
// - Accept the label after repeated equal frames, flag mismatch against expected.
// - Align on label bits 6 and 7, output a multiframe start pulse.
// - Enter out-of-multiframe on a single error in the bit 6,7 sequence.
// - Enter in-multiframe after four consecutive frames with error-free sequence.
// - When inactive, raise both signal-fail outputs and report no faults.
// - Declare multiframe loss after LOM_CYCLES clocks out of multiframe, set by parameter, not by register.
// - Clear multiframe loss as soon as in-multiframe is re-entered.
// - Report mismatch without trail-fail; loss only without trail-fail and mismatch.
// - Address downstream sinks by K.L.M within the allowed ranges.
// - Bits 6,7 run 01, 10, 11, 00 over the four multiframe frames.
`ifndef MLS_MAP_VH
`define MLS_MAP_VH

// Register byte offsets
`define MLS_CTRL_OFS      8'h00
`define MLS_STATUS_OFS    8'h04
`define MLS_IRQ_STAT_OFS  8'h08
`define MLS_IRQ_MASK_OFS  8'h0c
`define MLS_SINK_SEL_OFS  8'h10

// Field positions
`define MLS_CTRL_ACTIVE_BIT   0
`define MLS_ST_PLM_BIT        0
`define MLS_ST_LOM_BIT        1
`define MLS_ST_INMF_BIT       2
`define MLS_ST_PLMF_BIT       3
`define MLS_ST_LOMF_BIT       4
`define MLS_ST_LABEL_LSB      8
`define MLS_IRQ_PLM_BIT       0
`define MLS_IRQ_LOM_BIT       1
`define MLS_IRQ_UNLOCK_BIT    2
`define MLS_SEL_M_LSB         0
`define MLS_SEL_L_LSB         4
`define MLS_SEL_K_LSB         8

// Reset values
`define MLS_CTRL_RST      1'b0
`define MLS_IRQ_MASK_RST  3'h0
`define MLS_SINK_SEL_RST  7'h00

// Label codes and acceptance
`define MLS_EXPECTED_LABEL 3'h4
`define MLS_ACCEPT_FRAMES  5
`define MLS_ALIGN_FRAMES   4

// Multiframe loss time
`define MLS_LOM_TIME_US    3000
`define MLS_CLK_FREQ_MHZ   250

`endif

/* rtl/mls_sink.v */
`timescale 1ns/1ns
`include "mls_map.vh"

module mls_sink #(
  parameter integer LABEL_POS  = 0,
  parameter integer LOM_CYCLES = `MLS_LOM_TIME_US * `MLS_CLK_FREQ_MHZ
) (
  input  wire        CLK_I,
  input  wire        RST_I,
  // Upstream link, asynchronous to CLK_I
  input  wire        LINK_CK_I,
  input  wire        LINK_D_I,
  input  wire        LINK_FS_I,
  input  wire        INCOMING_TRAIL_FAIL_I,
  // Trail pass-through towards tributary sinks
  output reg         TRAIL_D_O,
  output reg         TRAIL_CK_O,
  output reg         TRAIL_FS_O,
  output wire        GROUP2_SIGNAL_FAIL_OUT_O,
  output wire        GROUP3_SIGNAL_FAIL_OUT_O,
  output reg         MULTIFRAME_START_OUT_O,
  // Selected downstream sink address
  output reg  [1:0]  SINK_K_O,
  output reg  [2:0]  SINK_L_O,
  output reg  [1:0]  SINK_M_O,
  output reg         SINK_SEL_VALID_O,
  // Faults to management
  output wire        LABEL_MISMATCH_FAULT_O,
  output wire        MULTIFRAME_LOSS_FAULT_O,
  output wire        IRQ_O,
  // AXI4-Lite slave
  input  wire [7:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output wire        S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output wire        S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [7:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output wire        S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I
);

  localparam ST_HUNT = 1'b0;
  localparam ST_LOCK = 1'b1;

  // Next phase of the four-frame label sequence
  function [1:0] phase_inc;
    input [1:0] ph;
    begin
      phase_inc = ph + 2'd1;
    end
  endfunction

  // K is 1..3 (A..C); L 0 only for group-3, 1..7 for A,B and 1..5 for C
  function klm_valid;
    input [1:0] k;
    input [2:0] l;
    input [1:0] m;
    begin
      klm_valid = (k != 2'd0) &&
                  ((l == 3'd0) ? ((k != 2'd3) && (m == 2'd0)) : !(k == 2'd3 && l > 3'd5));
    end
  endfunction

  // Two-flop synchronisers on every input from the link side
  reg  [3:0]  sync1_reg;
  reg  [3:0]  sync2_reg;
  reg         ck_dly_reg;
  wire        ck_s   = sync2_reg[0];
  wire        d_s    = sync2_reg[1];
  wire        fs_s   = sync2_reg[2];
  wire        tsf_s  = sync2_reg[3];
  wire        ck_rise = ck_s & ~ck_dly_reg;

  always @(posedge CLK_I) begin
    if (RST_I) begin
      sync1_reg  <= 4'h0;
      sync2_reg  <= 4'h0;
      ck_dly_reg <= 1'b0;
    end else begin
      sync1_reg  <= {INCOMING_TRAIL_FAIL_I, LINK_FS_I, LINK_D_I, LINK_CK_I};
      sync2_reg  <= sync1_reg;
      ck_dly_reg <= ck_s;
    end
  end

  // Control registers
  reg         active_reg;
  reg  [2:0]  irq_mask_reg;
  reg  [2:0]  irq_stat_reg;

  // Label extraction: bit counter restarts on the frame start bit
  reg  [15:0] bit_cnt_reg;
  reg  [6:0]  shift_reg;
  wire [15:0] cnt_here = fs_s ? 16'd0 : bit_cnt_reg;
  wire        label_done = ck_rise && (cnt_here == LABEL_POS + 7);
  wire [7:0]  label_byte = {shift_reg, d_s};
  wire [2:0]  label_struct = label_byte[5:3];
  wire [1:0]  label_mf = label_byte[2:1];

  always @(posedge CLK_I) begin
    if (RST_I) begin
      bit_cnt_reg <= 16'd0;
      shift_reg   <= 7'h00;
    end else if (ck_rise) begin
      shift_reg <= {shift_reg[5:0], d_s};
      bit_cnt_reg <= (cnt_here != 16'hffff) ? cnt_here + 16'd1 : cnt_here;  // Saturates
    end
  end

  // Label acceptance over consecutive equal frames
  reg  [2:0]  cand_reg;
  reg  [2:0]  accept_cnt_reg;
  reg  [2:0]  accepted_reg;
  wire        plm_defect = (accepted_reg != `MLS_EXPECTED_LABEL);

  always @(posedge CLK_I) begin
    if (RST_I) begin
      cand_reg       <= 3'h0;
      accept_cnt_reg <= 3'h0;
      accepted_reg   <= 3'h0;
    end else if (label_done) begin
      if (label_struct == cand_reg) begin
        if (accept_cnt_reg >= `MLS_ACCEPT_FRAMES - 1) begin
          accepted_reg <= cand_reg;
        end else begin
          accept_cnt_reg <= accept_cnt_reg + 3'd1;
        end
      end else begin
        cand_reg       <= label_struct;
        accept_cnt_reg <= 3'd1;
      end
    end
  end

  // Multiframe alignment; code 01 marks phase 0, so phase is code minus one
  reg         mf_state_reg;
  reg  [1:0]  exp_ph_reg;
  reg  [2:0]  good_cnt_reg;
  wire [1:0]  rx_ph = label_mf - 2'd1;
  wire        unlock_evt = label_done && mf_state_reg == ST_LOCK && rx_ph != exp_ph_reg;

  always @(posedge CLK_I) begin
    if (RST_I) begin
      mf_state_reg           <= ST_HUNT;
      exp_ph_reg             <= 2'd0;
      good_cnt_reg           <= 3'd0;
      MULTIFRAME_START_OUT_O <= 1'b0;
    end else begin
      MULTIFRAME_START_OUT_O <= 1'b0;
      if (label_done) begin
        exp_ph_reg <= phase_inc(rx_ph);
        case (mf_state_reg)
          ST_LOCK: begin
            if (rx_ph != exp_ph_reg) begin
              mf_state_reg <= ST_HUNT;
              good_cnt_reg <= 3'd1;
            end else if (rx_ph == 2'd0) begin
              MULTIFRAME_START_OUT_O <= 1'b1;
            end
          end
          default: begin
            if (good_cnt_reg == 3'd0 || rx_ph == exp_ph_reg) begin
              if (good_cnt_reg >= `MLS_ALIGN_FRAMES - 1) begin
                mf_state_reg <= ST_LOCK;
                good_cnt_reg <= 3'd0;
                MULTIFRAME_START_OUT_O <= (rx_ph == 2'd0);
              end else begin
                good_cnt_reg <= good_cnt_reg + 3'd1;
              end
            end else begin
              good_cnt_reg <= 3'd1;  // Restart hunt from this frame
            end
          end
        endcase
      end
    end
  end

  // Loss timer runs only while out of multiframe
  reg  [31:0] lom_cnt_reg;
  reg         lom_defect_reg;
  wire        lom_defect = lom_defect_reg & (mf_state_reg == ST_HUNT);  // Gone on lock edge

  always @(posedge CLK_I) begin
    if (RST_I) begin
      lom_cnt_reg    <= 32'd0;
      lom_defect_reg <= 1'b0;
    end else if (mf_state_reg == ST_LOCK) begin
      lom_cnt_reg    <= 32'd0;
      lom_defect_reg <= 1'b0;
    end else if (lom_cnt_reg >= LOM_CYCLES - 1) begin
      lom_defect_reg <= 1'b1;
    end else begin
      lom_cnt_reg <= lom_cnt_reg + 32'd1;
    end
  end

  // Consequent actions and fault correlation
  assign GROUP3_SIGNAL_FAIL_OUT_O = ~active_reg | plm_defect;
  assign GROUP2_SIGNAL_FAIL_OUT_O = ~active_reg | plm_defect | lom_defect;
  assign LABEL_MISMATCH_FAULT_O  = active_reg & plm_defect & ~tsf_s;
  assign MULTIFRAME_LOSS_FAULT_O = active_reg & lom_defect & ~tsf_s & ~plm_defect;

  // Trail pass-through, registered only to align with the fail flags
  always @(posedge CLK_I) begin
    if (RST_I) begin
      TRAIL_D_O  <= 1'b0;
      TRAIL_CK_O <= 1'b0;
      TRAIL_FS_O <= 1'b0;
    end else begin
      TRAIL_D_O  <= d_s;
      TRAIL_CK_O <= ck_s;
      TRAIL_FS_O <= fs_s;
    end
  end

  // Fault edges and multiframe unlock events feed the interrupt status
  reg         plm_fault_dly_reg;
  reg         lom_fault_dly_reg;
  wire [2:0]  irq_event = {unlock_evt & active_reg, MULTIFRAME_LOSS_FAULT_O & ~lom_fault_dly_reg,
                           LABEL_MISMATCH_FAULT_O & ~plm_fault_dly_reg};

  always @(posedge CLK_I) begin
    if (RST_I) begin
      plm_fault_dly_reg <= 1'b0;
      lom_fault_dly_reg <= 1'b0;
    end else begin
      plm_fault_dly_reg <= LABEL_MISMATCH_FAULT_O;
      lom_fault_dly_reg <= MULTIFRAME_LOSS_FAULT_O;
    end
  end

  assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

  // AXI4-Lite write channel: address and data latched in either order
  reg         aw_held_reg;
  reg         w_held_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  wire        do_write = aw_held_reg & w_held_reg & ~S_AXI_BVALID_O;
  wire        wr_lane0 = w_strb_reg[0];
  wire        wr_lane1 = w_strb_reg[1];
  wire        wr_hit = (aw_addr_reg == `MLS_CTRL_OFS) || (aw_addr_reg == `MLS_STATUS_OFS) ||
                       (aw_addr_reg == `MLS_IRQ_STAT_OFS) || (aw_addr_reg == `MLS_IRQ_MASK_OFS) ||
                       (aw_addr_reg == `MLS_SINK_SEL_OFS);
  wire [2:0]  irq_clr = (do_write && aw_addr_reg == `MLS_IRQ_STAT_OFS && wr_lane0) ?
                        w_data_reg[2:0] : 3'h0;

  assign S_AXI_AWREADY_O = ~aw_held_reg;
  assign S_AXI_WREADY_O  = ~w_held_reg;

  always @(posedge CLK_I) begin
    if (RST_I) begin
      aw_held_reg    <= 1'b0;
      w_held_reg     <= 1'b0;
      aw_addr_reg    <= 8'h00;
      w_data_reg     <= 32'h0;
      w_strb_reg     <= 4'h0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= 2'b00;
    end else begin
      if (S_AXI_AWVALID_I && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {S_AXI_AWADDR_I[7:2], 2'b00};
      end
      if (S_AXI_WVALID_I && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA_I;
        w_strb_reg <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_held_reg    <= 1'b0;
        w_held_reg     <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_hit ? 2'b00 : 2'b10;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Register writes; status is read-only, interrupt bits clear on one
  always @(posedge CLK_I) begin
    if (RST_I) begin
      active_reg       <= `MLS_CTRL_RST;
      irq_mask_reg     <= `MLS_IRQ_MASK_RST;
      irq_stat_reg     <= 3'h0;
      SINK_M_O         <= 2'd0;
      SINK_L_O         <= 3'd0;
      SINK_K_O         <= 2'd0;
      SINK_SEL_VALID_O <= 1'b0;
    end else begin
      // A new event in the clearing cycle survives the clear
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
      SINK_SEL_VALID_O <= klm_valid(SINK_K_O, SINK_L_O, SINK_M_O);
      if (do_write && aw_addr_reg == `MLS_CTRL_OFS && wr_lane0) begin
        active_reg <= w_data_reg[`MLS_CTRL_ACTIVE_BIT];
      end
      if (do_write && aw_addr_reg == `MLS_IRQ_MASK_OFS && wr_lane0) begin
        irq_mask_reg <= w_data_reg[2:0];
      end
      if (do_write && aw_addr_reg == `MLS_SINK_SEL_OFS) begin
        if (wr_lane0) begin
          SINK_M_O <= w_data_reg[`MLS_SEL_M_LSB +: 2];
          SINK_L_O <= w_data_reg[`MLS_SEL_L_LSB +: 3];
        end
        if (wr_lane1) begin
          SINK_K_O <= w_data_reg[`MLS_SEL_K_LSB +: 2];
        end
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  reg  [31:0] rd_word;
  reg         rd_hit;

  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;

  always @* begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    if ({S_AXI_ARADDR_I[7:2], 2'b00} == `MLS_CTRL_OFS) begin
      rd_word[`MLS_CTRL_ACTIVE_BIT] = active_reg;
    end else if ({S_AXI_ARADDR_I[7:2], 2'b00} == `MLS_STATUS_OFS) begin
      rd_word[`MLS_ST_PLM_BIT]  = plm_defect;
      rd_word[`MLS_ST_LOM_BIT]  = lom_defect;
      rd_word[`MLS_ST_INMF_BIT] = mf_state_reg;
      rd_word[`MLS_ST_PLMF_BIT] = LABEL_MISMATCH_FAULT_O;
      rd_word[`MLS_ST_LOMF_BIT] = MULTIFRAME_LOSS_FAULT_O;
      rd_word[`MLS_ST_LABEL_LSB +: 3] = accepted_reg;
    end else if ({S_AXI_ARADDR_I[7:2], 2'b00} == `MLS_IRQ_STAT_OFS) begin
      rd_word[2:0] = irq_stat_reg;
    end else if ({S_AXI_ARADDR_I[7:2], 2'b00} == `MLS_IRQ_MASK_OFS) begin
      rd_word[2:0] = irq_mask_reg;
    end else if ({S_AXI_ARADDR_I[7:2], 2'b00} == `MLS_SINK_SEL_OFS) begin
      rd_word[`MLS_SEL_M_LSB +: 2] = SINK_M_O;
      rd_word[`MLS_SEL_L_LSB +: 3] = SINK_L_O;
      rd_word[`MLS_SEL_K_LSB +: 2] = SINK_K_O;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0;
      S_AXI_RRESP_O  <= 2'b00;
    end else if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= rd_word;
      S_AXI_RRESP_O  <= rd_hit ? 2'b00 : 2'b10;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule // mls_sink

/* verif/mls_sink_sva.sv */
`timescale 1ns/1ns
module mls_sink_sva (
  input wire       CLK_I,
  input wire       RST_I,
  input wire       LINK_CK_I,
  input wire       LINK_D_I,
  input wire       LINK_FS_I,
  input wire       INCOMING_TRAIL_FAIL_I,
  input wire       TRAIL_CK_O,
  input wire       TRAIL_D_O,
  input wire       TRAIL_FS_O,
  input wire       GROUP2_SIGNAL_FAIL_OUT_O,
  input wire       GROUP3_SIGNAL_FAIL_OUT_O,
  input wire       MULTIFRAME_START_OUT_O,
  input wire       LABEL_MISMATCH_FAULT_O,
  input wire       MULTIFRAME_LOSS_FAULT_O,
  input wire       S_AXI_RVALID_O,
  input wire       S_AXI_ARREADY_O
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // Faults reported upward must show in the tributary fail outputs
  mm_fail3_a: assert property (LABEL_MISMATCH_FAULT_O |-> GROUP3_SIGNAL_FAIL_OUT_O)
    else $error("mismatch fault without group-3 fail");
  fail_nest_a: assert property (GROUP3_SIGNAL_FAIL_OUT_O |-> GROUP2_SIGNAL_FAIL_OUT_O)
    else $error("group-3 fail without group-2 fail");
  loss_fail2_a: assert property (MULTIFRAME_LOSS_FAULT_O |-> GROUP2_SIGNAL_FAIL_OUT_O)
    else $error("loss fault without group-2 fail");
  // Loss is hidden behind mismatch and behind an upstream trail fail
  fault_excl_a: assert property (MULTIFRAME_LOSS_FAULT_O |-> !LABEL_MISMATCH_FAULT_O)
    else $error("loss and mismatch faults together");
  tf_mute_a: assert property (INCOMING_TRAIL_FAIL_I [*4] |->
    !LABEL_MISMATCH_FAULT_O && !MULTIFRAME_LOSS_FAULT_O)
    else $error("fault reported under trail fail");
  // Start marks are single pulses at least eight clock cycles apart
  mfs_pulse_a: assert property (MULTIFRAME_START_OUT_O |=> !MULTIFRAME_START_OUT_O [*8])
    else $error("multiframe start not a lone pulse");
  mfs_noloss_a: assert property (MULTIFRAME_START_OUT_O |-> !MULTIFRAME_LOSS_FAULT_O)
    else $error("loss fault while aligned");
  // Two sync flops plus one output flop on each link signal
  trail_ck_a: assert property (TRAIL_CK_O == $past(LINK_CK_I, 3))
    else $error("trail clock not passed through");
  trail_d_a: assert property (TRAIL_D_O == $past(LINK_D_I, 3))
    else $error("trail data not passed through");
  trail_fs_a: assert property (TRAIL_FS_O == $past(LINK_FS_I, 3))
    else $error("trail frame start not passed through");
  rd_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read address taken with data pending");
endmodule // mls_sink_sva

bind mls_sink mls_sink_sva mls_sink_sva_inst (.*);

/* verif/mls_link_model.sv */
`timescale 1ns/1ns
module mls_link_model (
  output reg LINK_CK_O,
  output reg LINK_D_O,
  output reg LINK_FS_O
);
  // Link rests with its clock low until the first frame
  initial begin
    LINK_CK_O = 1'b0;
    LINK_D_O  = 1'b0;
    LINK_FS_O = 1'b0;
  end

  // Label byte MSB first, frame start on its first bit, two stuff bits;
  // odd start offset and a frame of whole clock periods keep link edges off clock edges
  task automatic frame(input [2:0] lbl, input [1:0] ph);
    reg     [9:0] bits;
    integer       i;
    begin
      bits = {2'b00, lbl, ph, 1'b0, 2'b10};
      #3;
      for (i = 9; i >= 0; i = i - 1) begin
        LINK_D_O = bits[i];
        LINK_FS_O = (i == 9);
        #16 LINK_CK_O = 1'b1;
        #16 LINK_CK_O = 1'b0;
      end
      // Clock stops between frames; data no longer holds its last bit
      LINK_FS_O = 1'b0;
      LINK_D_O = ~LINK_D_O;
      #65;
    end
  endtask
endmodule // mls_link_model

/* verif/tb_top.sv */
`timescale 1ns/1ns
`include "mls_map.vh"
module tb_top;
  reg         CLK_I = 1'b0;
  reg         RST_I = 1'b1;
  reg         INCOMING_TRAIL_FAIL_I = 1'b0;
  reg  [7:0]  S_AXI_AWADDR_I = 8'h00;
  reg  [7:0]  S_AXI_ARADDR_I = 8'h00;
  reg  [31:0] S_AXI_WDATA_I = 32'h0;
  reg  [3:0]  S_AXI_WSTRB_I = 4'hf;
  reg         S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
  reg         S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
  wire        LINK_CK_I, LINK_D_I, LINK_FS_I, TRAIL_D_O, TRAIL_CK_O, TRAIL_FS_O;
  wire        GROUP2_SIGNAL_FAIL_OUT_O, GROUP3_SIGNAL_FAIL_OUT_O, MULTIFRAME_START_OUT_O;
  wire [1:0]  SINK_K_O, SINK_M_O, S_AXI_BRESP_O, S_AXI_RRESP_O;
  wire [2:0]  SINK_L_O;
  wire        SINK_SEL_VALID_O, LABEL_MISMATCH_FAULT_O, MULTIFRAME_LOSS_FAULT_O, IRQ_O;
  wire        S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  wire [31:0] S_AXI_RDATA_O;
  integer     fails = 0, checked = 0, mfs_n = 0, m0, i;
  reg  [1:0]  ph = 2'b01;
  // Fail outputs then faults, for compact comparisons
  wire [3:0]  fl = {GROUP3_SIGNAL_FAIL_OUT_O, GROUP2_SIGNAL_FAIL_OUT_O,
                    LABEL_MISMATCH_FAULT_O, MULTIFRAME_LOSS_FAULT_O};
  // K.L.M cases: A.0.0 C.0.0 A.7.3 C.6.1 C.5.3 B.1.0 -.1.1 A.0.1
  localparam [55:0] SELS = {7'b0100000, 7'b1100000, 7'b0111111, 7'b1111001,
                            7'b1110111, 7'b1000100, 7'b0000101, 7'b0100001};

  // Short loss time keeps the run brief
  mls_sink #(.LOM_CYCLES(200)) mls_sink_inst (.*);
  mls_link_model mls_link_model_inst (
    .LINK_CK_O (LINK_CK_I),
    .LINK_D_O  (LINK_D_I),
    .LINK_FS_O (LINK_FS_I)
  );

  always #2 CLK_I = ~CLK_I;

  // Count start pulses seen
  always @(posedge CLK_I) if (MULTIFRAME_START_OUT_O) mfs_n <= mfs_n + 1;

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Address and data offered together, each dropped when taken
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg     aw, w;
    integer n;
    begin
      @(posedge CLK_I);
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= d;
      S_AXI_AWVALID_I <= 1'b1;
      S_AXI_WVALID_I <= 1'b1;
      S_AXI_BREADY_I <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      do begin
        @(posedge CLK_I);
        n = n + 1;
        if (aw && S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
        if (w && S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
        aw = aw && !S_AXI_AWREADY_O;
        w = w && !S_AXI_WREADY_O;
      end while ((aw || w || !S_AXI_BVALID_O) && n < 50);
      S_AXI_BREADY_I <= 1'b0;
      chk({S_AXI_BVALID_O, S_AXI_BRESP_O}, {1'b1, er});
    end
  endtask

  // Read, then compare masked data and the response
  task rc(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
    integer n;
    begin
      @(posedge CLK_I);
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'b1;
      S_AXI_RREADY_I <= 1'b1;
      n = 0;
      do begin
        @(posedge CLK_I);
        n = n + 1;
        if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
      end while (!S_AXI_RVALID_O && n < 50);
      S_AXI_RREADY_I <= 1'b0;
      chk({S_AXI_RVALID_O, S_AXI_RRESP_O}, {1'b1, er});
      chk(S_AXI_RDATA_O & m, e);
    end
  endtask

  // Frames with codes 01, 10, 11, 00 in turn
  task frames(input [2:0] l, input integer n);
    repeat (n) begin
      mls_link_model_inst.frame(l, ph);
      ph = ph + 2'd1;
    end
  endtask

  function legal(input [6:0] c);
    legal = (c[6:5] != 2'd0) && ((c[4:2] == 3'd0) ? (c[6:5] != 2'd3 && c[1:0] == 2'd0)
            : (c[4:2] <= ((c[6:5] == 2'd3) ? 3'd5 : 3'd7)));
  endfunction

  task t_reset;
    begin
      chk({IRQ_O, MULTIFRAME_START_OUT_O, fl}, 6'b001100);
      rc(`MLS_CTRL_OFS, 32'hffffffff, 32'h0, 2'b00);
      rc(`MLS_IRQ_MASK_OFS, 32'hffffffff, 32'h0, 2'b00);
      rc(8'h20, 32'hffffffff, 32'h0, 2'b10);
      wr(8'h20, 32'h1, 2'b10);
    end
  endtask

  // Inactive and never aligned: fails forced, faults silent
  task t_inact;
    begin
      repeat (3) mls_link_model_inst.frame(3'h2, 2'b01);
      chk(fl, 4'b1100);
    end
  endtask

  task t_align;
    begin
      wr(`MLS_CTRL_OFS, 32'h1, 2'b00);
      m0 = mfs_n;
      frames(3'h4, 8);
      rc(`MLS_STATUS_OFS, 32'h71f, 32'h404, 2'b00);
      chk(mfs_n - m0, 1);
      chk(fl, 4'b0000);
      wr(`MLS_CTRL_OFS, 32'h0, 2'b00);
      chk(fl, 4'b1100);
      wr(`MLS_CTRL_OFS, 32'h1, 2'b00);
    end
  endtask

  task t_oom;
    begin
      wr(`MLS_IRQ_MASK_OFS, 32'h2, 2'b00);
      ph = ph + 2'd1;
      frames(3'h4, 1);
      rc(`MLS_STATUS_OFS, 32'h7, 32'h0, 2'b00);
      frames(3'h4, 2);
      rc(`MLS_STATUS_OFS, 32'h7, 32'h2, 2'b00);
      chk({IRQ_O, fl}, 5'b10101);
      frames(3'h4, 1);
      rc(`MLS_STATUS_OFS, 32'h7, 32'h4, 2'b00);
      rc(`MLS_IRQ_STAT_OFS, 32'h7, 32'h7, 2'b00);
      wr(`MLS_IRQ_MASK_OFS, 32'h0, 2'b00);
      chk(IRQ_O, 1'b0);
      wr(`MLS_IRQ_MASK_OFS, 32'h2, 2'b00);
      chk(IRQ_O, 1'b1);
      wr(`MLS_IRQ_STAT_OFS, 32'h7, 2'b00);
      chk(IRQ_O, 1'b0);
      rc(`MLS_IRQ_STAT_OFS, 32'h7, 32'h0, 2'b00);
    end
  endtask

  task t_plm;
    begin
      frames(3'h2, 4);
      rc(`MLS_STATUS_OFS, 32'h1, 32'h0, 2'b00);
      frames(3'h2, 1);
      rc(`MLS_STATUS_OFS, 32'h71f, 32'h20d, 2'b00);
      chk(fl, 4'b1110);
      ph = ph + 2'd1;
      frames(3'h2, 1);
      repeat (260) @(posedge CLK_I);
      rc(`MLS_STATUS_OFS, 32'h1f, 32'h0b, 2'b00);
      chk(fl, 4'b1110);
      @(posedge CLK_I) INCOMING_TRAIL_FAIL_I <= 1'b1;
      repeat (5) @(posedge CLK_I);
      chk(fl, 4'b1100);
      @(posedge CLK_I) INCOMING_TRAIL_FAIL_I <= 1'b0;
      wr(`MLS_CTRL_OFS, 32'h0, 2'b00);
      repeat (5) @(posedge CLK_I);
      chk(fl, 4'b1100);
    end
  endtask

  task t_sel;
    reg [6:0] c;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        c = SELS[i*7 +: 7];
        wr(`MLS_SINK_SEL_OFS, {22'h0, c[6:5], 1'b0, c[4:2], 2'b00, c[1:0]}, 2'b00);
        repeat (2) @(posedge CLK_I);
        chk({SINK_K_O, SINK_L_O, SINK_M_O, SINK_SEL_VALID_O}, {c, legal(c)});
      end
    end
  endtask

  task test_done;
    begin
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_reset;
    t_inact;
    t_align;
    t_oom;
    t_plm;
    t_sel;
    test_done;
  end

  // Whole run needs about 10 us; this cuts a hang short
  initial begin
    #100000;
    fails = fails + 1;
    test_done;
  end
endmodule // tb_top
